/* File: hdl/sadr_decoder.sv */
`timescale 1ns/10ps
// What this block does
// - split 4 GB into sixteen 256 MB regions by top four address bits
// - regions one to six go to external memory, each its own chip select
// - region zero holds on-chip memories, subdecoded into 1 MB areas
// - region fifteen forwards to the peripheral bus
// - unassigned regions answer the requesting master with an abort
// - before remap the sram answers only at its fixed base
// - after remap the sram also answers at address zero
// - boot rom always answers at its fixed base
// - with boot source high, rom aliases at zero until remap
module sadr_decoder #(
	parameter int ROM_AW  = sadr_pkg::ROM_AW_DEF,
	parameter int SRAM_AW = sadr_pkg::SRAM_AW_DEF
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hready,
	input  wire logic        remap_cmd,
	input  wire logic        boot_source_select,
	output logic             sel_rom_q,
	output logic             sel_sram_q,
	output logic             sel_ext_q,
	output logic             sel_periph_q,
	output logic [5:0]       ext_chip_select_q,
	output logic             remapped_q,
	output logic             err_hready_q,
	output logic             err_hresp_q,
	output logic             err_active_q
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	sadr_pkg::sadr_target_t target;
	logic [5:0]             cs_onehot;
	logic                   active;
	logic                   err_first_q;
	logic                   boot_rom_q;
	logic                   boot_taken_q;

	assign active = hready && htrans[1];

	sadr_region_decode #(
		.ROM_AW  (ROM_AW),
		.SRAM_AW (SRAM_AW)
	) u_dec (
		.addr      (haddr),
		.remapped  (remapped_q),
		.boot_rom  (boot_rom_q),
		.target    (target),
		.cs_onehot (cs_onehot)
	);

	// ----------------------------------------
	// remap flag and boot strap
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			remapped_q <= 1'b0;
		end else if (remap_cmd) begin
			remapped_q <= 1'b1;
		end
	end

	// strap caught on first clock after reset release, not by the async reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			boot_taken_q <= 1'b0;
			boot_rom_q   <= 1'b0;
		end else if (!boot_taken_q) begin
			boot_taken_q <= 1'b1;
			boot_rom_q   <= boot_source_select;
		end
	end

	// ----------------------------------------
	// address phase selects, registered for data phase
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_rom_q         <= 1'b0;
			sel_sram_q        <= 1'b0;
			sel_ext_q         <= 1'b0;
			sel_periph_q      <= 1'b0;
			ext_chip_select_q <= '0;
		end else if (hready) begin
			sel_rom_q         <= active && target == sadr_pkg::TGT_ROM;
			sel_sram_q        <= active && target == sadr_pkg::TGT_SRAM;
			sel_ext_q         <= active && target == sadr_pkg::TGT_EXT;
			sel_periph_q      <= active && target == sadr_pkg::TGT_PERIPH;
			ext_chip_select_q <= active ? cs_onehot : '0;
		end
	end

	// ----------------------------------------
	// two-cycle error response
	// ----------------------------------------
	// no target select rises for an unmapped access, so nothing is touched
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_first_q  <= 1'b0;
			err_hready_q <= 1'b1;
			err_hresp_q  <= sadr_pkg::HRESP_OKAY;
			err_active_q <= 1'b0;
		end else if (active && target == sadr_pkg::TGT_NONE) begin
			err_first_q  <= 1'b1;
			err_hready_q <= 1'b0;
			err_hresp_q  <= sadr_pkg::HRESP_ERROR;
			err_active_q <= 1'b1;
		end else if (err_first_q) begin
			err_first_q  <= 1'b0;
			err_hready_q <= 1'b1;
			err_hresp_q  <= sadr_pkg::HRESP_ERROR;
			err_active_q <= 1'b1;
		end else begin
			err_hready_q <= 1'b1;
			err_hresp_q  <= sadr_pkg::HRESP_OKAY;
			err_active_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_err_two_cycle;
		@(posedge clock) disable iff (!rst_n)
		$rose(err_first_q) |-> !err_hready_q && err_hresp_q ##1 err_hready_q && err_hresp_q;
	endproperty
	a_err_two_cycle: assert property (p_err_two_cycle) else $error("bad error response");

	property p_unmapped_aborts;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:28] inside {[4'h7:4'hE]} |=> err_active_q && !sel_ext_q;
	endproperty
	a_unmapped_aborts: assert property (p_unmapped_aborts) else $error("no abort");

	property p_ext_cs;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:28] == 4'h1 |=> ext_chip_select_q == 6'h01 && sel_ext_q;
	endproperty
	a_ext_cs: assert property (p_ext_cs) else $error("bad chip select");

	property p_periph;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:28] == 4'hF |=> sel_periph_q && ext_chip_select_q == 6'h00;
	endproperty
	a_periph: assert property (p_periph) else $error("periph not selected");

	property p_rom_base;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:20] == 12'h001 && haddr[19:16] == 4'h0 |=> sel_rom_q;
	endproperty
	a_rom_base: assert property (p_rom_base) else $error("rom missing");

	property p_sram_zero_pre;
		@(posedge clock) disable iff (!rst_n)
		active && !remapped_q && haddr[31:20] == 12'h000 |=> !sel_sram_q;
	endproperty
	a_sram_zero_pre: assert property (p_sram_zero_pre) else $error("early sram alias");

	property p_sram_zero_post;
		@(posedge clock) disable iff (!rst_n)
		active && remapped_q && haddr[31:15] == 17'h0 |=> sel_sram_q && !sel_rom_q;
	endproperty
	a_sram_zero_post: assert property (p_sram_zero_post) else $error("no sram alias");

	property p_rom_alias;
		@(posedge clock) disable iff (!rst_n)
		active && boot_rom_q && !remapped_q && haddr[31:16] == 16'h0 |=> sel_rom_q;
	endproperty
	a_rom_alias: assert property (p_rom_alias) else $error("no rom alias");

	property p_remap_sticky;
		@(posedge clock) disable iff (!rst_n)
		remapped_q |=> remapped_q;
	endproperty
	a_remap_sticky: assert property (p_remap_sticky) else $error("remap lost");

	property p_ext_cs_onehot;
		@(posedge clock) disable iff (!rst_n)
		sel_ext_q ? $onehot(ext_chip_select_q) : (ext_chip_select_q == 6'h00);
	endproperty
	a_ext_cs_onehot: assert property (p_ext_cs_onehot) else $error("bad select code");

	property p_ext_cs_top;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:28] == 4'h6 |=> ext_chip_select_q == 6'h20 && sel_ext_q;
	endproperty
	a_ext_cs_top: assert property (p_ext_cs_top) else $error("bad top select");

	property p_sram_base;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:15] == 17'h0_0060 |=> sel_sram_q && !sel_rom_q;
	endproperty
	a_sram_base: assert property (p_sram_base) else $error("sram base missing");

	property p_rom_zero_off;
		@(posedge clock) disable iff (!rst_n)
		active && !boot_rom_q && !remapped_q && haddr[31:20] == 12'h000 |=>
			!sel_rom_q && err_active_q;
	endproperty
	a_rom_zero_off: assert property (p_rom_zero_off) else $error("stray rom alias");

	property p_area_gap;
		@(posedge clock) disable iff (!rst_n)
		active && haddr[31:20] == 12'h002 |=> err_active_q && !sel_sram_q && !sel_rom_q;
	endproperty
	a_area_gap: assert property (p_area_gap) else $error("gap not aborted");

	// an idle slot must leave every target and the error path quiet
	property p_idle_quiet;
		@(posedge clock) disable iff (!rst_n)
		hready && !htrans[1] |=>
			!sel_rom_q && !sel_sram_q && !sel_ext_q && !sel_periph_q && !err_active_q;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle selects");

	property p_remap_sets;
		@(posedge clock) disable iff (!rst_n)
		remap_cmd |=> remapped_q;
	endproperty
	a_remap_sets: assert property (p_remap_sets) else $error("remap not set");

	property p_strap_hold;
		@(posedge clock) disable iff (!rst_n)
		boot_taken_q |=> $stable(boot_rom_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
endmodule

/* File: hdl/sadr_pkg.sv */
package sadr_pkg;
	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam int           ADDR_W       = 32;
	localparam int           REGION_MSB   = 31;
	localparam int           REGION_LSB   = 28;
	localparam logic [3:0]   REGION_MEM   = 4'h0;
	localparam logic [3:0]   REGION_EXT_LO = 4'h1;
	localparam logic [3:0]   REGION_EXT_HI = 4'h6;
	localparam logic [3:0]   REGION_PERIPH = 4'hF;
	localparam int           NUM_CS       = 6;
	localparam int           AREA_MSB     = 27;
	localparam int           AREA_LSB     = 20;
	localparam logic [7:0]   AREA_ZERO    = 8'h00;
	localparam logic [7:0]   AREA_ROM     = 8'h01;
	localparam logic [7:0]   AREA_SRAM    = 8'h03;
	localparam int           ROM_AW_DEF   = 16;
	localparam int           SRAM_AW_DEF  = 15;
	// ----------------------------------------
	// ahb encodings
	// ----------------------------------------
	localparam logic [1:0]   HTRANS_IDLE  = 2'h0;
	localparam logic [1:0]   HTRANS_BUSY  = 2'h1;
	localparam logic         HRESP_OKAY   = 1'b0;
	localparam logic         HRESP_ERROR  = 1'b1;
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_ROM,
		TGT_SRAM,
		TGT_EXT,
		TGT_PERIPH
	} sadr_target_t;
endpackage

/* File: hdl/sadr_region_decode.sv */
`timescale 1ns/10ps
// ----------------------------------------
// combinational target decode of one address
// ----------------------------------------
module sadr_region_decode #(
	parameter int ROM_AW  = sadr_pkg::ROM_AW_DEF,
	parameter int SRAM_AW = sadr_pkg::SRAM_AW_DEF
) (
	input  wire logic [31:0]          addr,
	input  wire logic                 remapped,
	input  wire logic                 boot_rom,
	output sadr_pkg::sadr_target_t    target,
	output logic      [5:0]           cs_onehot
);
	logic [3:0] region;
	logic [7:0] area;
	logic       sram_fits;
	logic       rom_fits;

	assign region    = addr[sadr_pkg::REGION_MSB:sadr_pkg::REGION_LSB];
	assign area      = addr[sadr_pkg::AREA_MSB:sadr_pkg::AREA_LSB];
	// memories smaller than the 1 MB area abort above their size
	assign sram_fits = (addr[sadr_pkg::AREA_LSB-1:SRAM_AW] == '0);
	assign rom_fits  = (addr[sadr_pkg::AREA_LSB-1:ROM_AW] == '0);

	always_comb begin
		target    = sadr_pkg::TGT_NONE;
		cs_onehot = '0;
		if (region == sadr_pkg::REGION_MEM) begin
			if (area == sadr_pkg::AREA_ROM && rom_fits) begin
				target = sadr_pkg::TGT_ROM;
			end else if (area == sadr_pkg::AREA_SRAM && sram_fits) begin
				target = sadr_pkg::TGT_SRAM;
			end else if (area == sadr_pkg::AREA_ZERO) begin
				// sram alias wins over rom alias once remapped
				if (remapped && sram_fits) begin
					target = sadr_pkg::TGT_SRAM;
				end else if (!remapped && boot_rom && rom_fits) begin
					target = sadr_pkg::TGT_ROM;
				end
			end
		end else if (region >= sadr_pkg::REGION_EXT_LO &&
				region <= sadr_pkg::REGION_EXT_HI) begin
			target = sadr_pkg::TGT_EXT;
			cs_onehot[3'(region - sadr_pkg::REGION_EXT_LO)] = 1'b1;
		end else if (region == sadr_pkg::REGION_PERIPH) begin
			target = sadr_pkg::TGT_PERIPH;
		end
	end
endmodule

/* File: tb/sadr_master_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// ahb master stand-in
// ----------------------------------------
module sadr_master_model (
	input  wire logic        clock,
	input  wire logic        err_hready_q,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hready
);
	logic stall;
	// stall mimics a slow target ahead of this transfer
	assign hready = err_hready_q & ~stall;
	initial begin
		haddr = 32'h0000_0000;
		htrans = sadr_pkg::HTRANS_IDLE;
		stall = 1'b0;
	end
	// call at a falling edge; returns at the rising edge that takes the transfer
	task automatic present(input logic [31:0] a, input logic [1:0] waits);
		haddr = a;
		htrans = 2'h2;
		stall = (waits != 2'h0);
		repeat (waits) @(negedge clock);
		stall = 1'b0;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
	endtask
	// released lines show the inverse, never the stale address
	task automatic release_bus();
		if (htrans !== sadr_pkg::HTRANS_IDLE) begin
			htrans = sadr_pkg::HTRANS_IDLE;
			haddr = ~haddr;
		end
	endtask
endmodule

/* File: tb/sadr_decoder_test.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module sadr_decoder_test;
	logic        clock;
	logic        rst_n;
	logic        remap_cmd;
	logic        boot_source_select;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hready;
	logic [5:0]  cs;
	logic        rom, sram, ext, per, rmp, ehr, ehp, eact;
	logic [10:0] seen;
	int          n_fail;
	int          checks_done;
	int          cyc;
	int          seed;
	logic        rm;
	logic        bt;
	logic [31:0] corner [12] = '{32'h0000_0000, 32'h0000_FFFC, 32'h0001_0000, 32'h0000_8000,
		32'h0010_0000, 32'h0010_FFFC, 32'h0011_0000, 32'h0030_0000, 32'h0030_7FFC,
		32'h0030_8000, 32'h0020_0000, 32'h7000_0000};
	assign seen = {rom, sram, ext, per, cs, ehp};
	sadr_decoder dut (
		.clock(clock), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hready(hready),
		.remap_cmd(remap_cmd), .boot_source_select(boot_source_select),
		.sel_rom_q(rom), .sel_sram_q(sram), .sel_ext_q(ext), .sel_periph_q(per),
		.ext_chip_select_q(cs), .remapped_q(rmp), .err_hready_q(ehr),
		.err_hresp_q(ehp), .err_active_q(eact));
	sadr_master_model m (
		.clock(clock), .err_hready_q(ehr), .haddr(haddr), .htrans(htrans), .hready(hready));
	// ----------------------------------------
	// expectation: {rom, sram, ext, periph, chip selects, error}
	// ----------------------------------------
	function automatic logic [10:0] exp_sel(input logic [31:0] a, input logic r_m,
		input logic b_t);
		logic [3:0] r;
		logic [7:0] ar;
		r = a[31:28];
		ar = a[27:20];
		if (r == 4'h0) begin
			if (a[19:16] == 4'h0 && (ar == 8'h01 || (ar == 8'h00 && !r_m && b_t)))
				return 11'h400;
			if (a[19:15] == 5'h00 && (ar == 8'h03 || (ar == 8'h00 && r_m)))
				return 11'h200;
			return 11'h001;
		end
		if (r >= 4'h1 && r <= 4'h6)
			return {4'h2, 6'h01 << (r - 4'h1), 1'b0};
		if (r == 4'hF)
			return 11'h080;
		return 11'h001;
	endfunction
	task automatic do_acc(input logic [31:0] ad, input logic [1:0] w);
		logic [10:0] e;
		e = exp_sel(ad, rm, bt);
		m.present(ad, w);
		@(negedge clock);
		`CHK("select", e, seen)
		if (e[0]) begin
			m.release_bus();
			`CHK("err_first", 2'h1, {ehr, eact})
			@(negedge clock);
			`CHK("err_second", 3'h7, {ehr, ehp, eact})
		end
	endtask
	task automatic do_reset(input logic b);
		rst_n = 1'b0;
		boot_source_select = b;
		bt = b;
		rm = 1'b0;
		repeat (6) @(negedge clock);
		`CHK("reset", 14'h0002, {seen, rmp, ehr, eact})
		rst_n = 1'b1;
		@(negedge clock);
	endtask
	task automatic do_remap();
		remap_cmd = 1'b1;
		@(negedge clock);
		remap_cmd = 1'b0;
		rm = 1'b1;
		repeat (3) @(negedge clock);
		`CHK("remapped", 1'b1, rmp)
	endtask
	task automatic sweep();
		foreach (corner[i]) do_acc(corner[i], 2'(i % 3));
		for (int r = 0; r < 16; r++) do_acc({4'(r), 28'($random(seed))}, 2'h0);
		m.release_bus();
	endtask
	task automatic rand_run(input int n);
		logic [31:0] a;
		for (int i = 0; i < n; i++) begin
			a = $random(seed);
			// bias toward region zero so its small areas get hit
			if (a[0])
				a[31:20] = {10'h000, a[2:1]};
			if (a[3])
				a[19:16] = 4'h0;
			do_acc(a, a[5:4]);
		end
		m.release_bus();
	endtask
	task automatic results();
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		seed = 32'h7d5a;
		n_fail = 0;
		checks_done = 0;
		cyc = 0;
		remap_cmd = 1'b0;
		do_reset(1'b1);
		sweep();
		do_remap();
		sweep();
		do_reset(1'b0);
		sweep();
		// strap is taken once after reset, a late change must not alias the rom
		boot_source_select = 1'b1;
		rand_run(300);
		do_remap();
		rand_run(300);
		results();
	end
endmodule
